// >>> jrt_ram_test.sv
`timescale 1ns/10ps
// Summary of operation
// - Three-bit index picks one of eight SRAMs
// - Bit 13 selects luminance (1) or chrominance
// - Bit 14 makes reads use output buffer
// - Output buffer bit ignored on writes
// - Write copies data into all seventeen memories
// - Write-enable zero reads selected memory into data
// - Only data register accesses start memory cycles
// - Eleven-bit indirect address held in bits 10:0
// - Ten-bit word address, auto-increments, wraps from 799 to 0
// - Data register accesses act on indirect target
// - Route bit chooses indirect registers or memories
module jrt_ram_test (
	input wire logic mclk,
	input wire logic rst,
	input wire jrt_pkg::jrt_req_s req,
	input wire logic memory_test_route_select,
	input wire logic [15:0] ind_reg_rdata,
	output logic [15:0] rdata_q,
	output logic rvalid_q,
	output logic ind_reg_wr_q,
	output logic [10:0] ind_reg_addr_q,
	output logic [15:0] ind_reg_wdata_q
);
	logic [15:0] ram_test_control_q;
	logic [15:0] indirect_access_control_q;
	logic [15:0] indirect_data_register_q;
	logic rd_pend_q;
	logic mem_rd_pend_q;
	logic data_acc;
	jrt_pkg::jrt_mem_s mreq;
	logic [15:0] mem_rdata;
	logic [9:0] word_addr;

	// Maps bank, index and output-buffer bit to memory number
	function automatic logic [4:0] mem_select(input logic [15:0] ctl);
		logic [4:0] s;
		s = {2'h0, ctl[jrt_pkg::POS_SRAM_IDX_HI:jrt_pkg::POS_SRAM_IDX_LO]};
		if (!ctl[jrt_pkg::POS_BANK_LUMA])
			s = s + 5'(jrt_pkg::CHROMA_BASE);
		if (ctl[jrt_pkg::POS_OUTBUF])
			s = 5'(jrt_pkg::OUTBUF_IDX);
		return s;
	endfunction

	assign word_addr = ram_test_control_q[jrt_pkg::POS_WORD_ADDR_HI:jrt_pkg::POS_WORD_ADDR_LO];
	assign data_acc = (req.wr || req.rd) && req.addr == jrt_pkg::OFS_IND_DATA;

	// ----------------------------------------------------------------
	// Memory request
	// ----------------------------------------------------------------
	always_comb
	begin
		mreq.addr = word_addr;
		mreq.sel = mem_select(ram_test_control_q);
		mreq.wdata = req.wdata;
		mreq.we = data_acc && req.wr && memory_test_route_select
			&& ram_test_control_q[jrt_pkg::POS_WR_EN];
		mreq.re = data_acc && req.rd && memory_test_route_select
			&& !ram_test_control_q[jrt_pkg::POS_WR_EN];
	end

	jrt_mem #(
		.N(jrt_pkg::NUM_MEMS),
		.DEPTH(jrt_pkg::MEM_WORDS)
	) u_mem (
		.mclk(mclk),
		.addr(mreq.addr),
		.sel(mreq.sel),
		.we(mreq.we),
		.re(mreq.re),
		.wdata(mreq.wdata),
		.rdata_q(mem_rdata)
	);

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			ram_test_control_q <= jrt_pkg::RST_RAM_TEST_CTRL;
		else if (req.wr && req.addr == jrt_pkg::OFS_RAM_TEST_CTRL)
			ram_test_control_q <= req.wdata;
		else if (mreq.we || mreq.re)
		begin
			if (word_addr == jrt_pkg::LAST_WORD)
				ram_test_control_q[jrt_pkg::POS_WORD_ADDR_HI:0] <= 10'h000;
			else
				ram_test_control_q[jrt_pkg::POS_WORD_ADDR_HI:0] <= word_addr + 10'h001;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			indirect_access_control_q <= jrt_pkg::RST_IND_CTRL;
		else if (req.wr && req.addr == jrt_pkg::OFS_IND_CTRL)
			indirect_access_control_q <= req.wdata;
	end

	// ----------------------------------------------------------------
	// Indirect data register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			indirect_data_register_q <= 16'h0000;
		else if (mem_rd_pend_q)
			indirect_data_register_q <= mem_rdata;
		else if (data_acc && req.wr)
			indirect_data_register_q <= req.wdata;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ind_reg_wr_q <= 1'b0;
			ind_reg_addr_q <= 11'h000;
			ind_reg_wdata_q <= 16'h0000;
		end
		else
		begin
			ind_reg_wr_q <= data_acc && req.wr && !memory_test_route_select;
			ind_reg_addr_q <= indirect_access_control_q[jrt_pkg::POS_IND_ADDR_HI:0];
			ind_reg_wdata_q <= req.wdata;
		end
	end

	// ----------------------------------------------------------------
	// Read answer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			rd_pend_q <= 1'b0;
			mem_rd_pend_q <= 1'b0;
			rdata_q <= 16'h0000;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rd_pend_q <= req.rd && !mreq.re;
			mem_rd_pend_q <= mreq.re;
			rvalid_q <= 1'b0;
			if (mem_rd_pend_q)
			begin
				rdata_q <= mem_rdata;
				rvalid_q <= 1'b1;
			end
			else if (rd_pend_q)
				rvalid_q <= 1'b1;
			if (req.rd && !mreq.re)
			begin
				unique case (req.addr)
					jrt_pkg::OFS_RAM_TEST_CTRL: rdata_q <= ram_test_control_q;
					jrt_pkg::OFS_IND_CTRL: rdata_q <= indirect_access_control_q;
					jrt_pkg::OFS_IND_DATA: rdata_q <= ind_reg_rdata;
					default: rdata_q <= 16'h0000;
				endcase
			end
		end
	end
endmodule

// >>> jrt_pkg.sv
package jrt_pkg;
	// Register offsets
	localparam logic [7:0] OFS_RAM_TEST_CTRL = 8'h1D;
	localparam logic [7:0] OFS_IND_CTRL = 8'h1E;
	localparam logic [7:0] OFS_IND_DATA = 8'h1F;
	// Reset values
	localparam logic [15:0] RST_RAM_TEST_CTRL = 16'h0000;
	localparam logic [15:0] RST_IND_CTRL = 16'h0000;
	// Field positions in ram_test_control
	localparam int POS_WORD_ADDR_LO = 0;
	localparam int POS_WORD_ADDR_HI = 9;
	localparam int POS_SRAM_IDX_LO = 10;
	localparam int POS_SRAM_IDX_HI = 12;
	localparam int POS_BANK_LUMA = 13;
	localparam int POS_OUTBUF = 14;
	localparam int POS_WR_EN = 15;
	// Field positions in indirect_access_control
	localparam int POS_IND_ADDR_HI = 10;
	// Memory geometry
	localparam int NUM_MEMS = 17;
	localparam int MEM_WORDS = 800;
	localparam logic [9:0] LAST_WORD = 10'h31F;
	localparam int OUTBUF_IDX = 16;
	localparam int CHROMA_BASE = 8;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} jrt_req_s;

	typedef struct packed {
		logic [9:0] addr;
		logic [4:0] sel;
		logic we;
		logic re;
		logic [15:0] wdata;
	} jrt_mem_s;
endpackage

// >>> jrt_mem.sv
`timescale 1ns/10ps
// Bank of test memories; write goes to all, read from one, registered data
module jrt_mem #(
	parameter int N = 17,
	parameter int DEPTH = 800
)(
	input wire logic mclk,
	input wire logic [9:0] addr,
	input wire logic [4:0] sel,
	input wire logic we,
	input wire logic re,
	input wire logic [15:0] wdata,
	output logic [15:0] rdata_q
);
	logic [15:0] mem [N][DEPTH];
	logic [15:0] rd_all [N];

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_mem
			always_ff @(posedge mclk)
			begin
				if (we)
					mem[g][addr] <= wdata;
			end
			assign rd_all[g] = mem[g][addr];
		end
	endgenerate

	always_ff @(posedge mclk)
	begin
		if (re)
			rdata_q <= rd_all[sel];
	end
endmodule

// >>> jrt_ind_model.sv
`timescale 1ns/10ps
module jrt_ind_model (
	input wire logic mclk,
	input wire logic ind_reg_wr_q,
	input wire logic [10:0] ind_reg_addr_q,
	input wire logic [15:0] ind_reg_wdata_q,
	output logic [15:0] ind_reg_rdata
);
	logic [15:0] regs_q [0:2047];
	assign ind_reg_rdata = regs_q[ind_reg_addr_q];
	always_ff @(posedge mclk)
	begin
		if (ind_reg_wr_q)
			regs_q[ind_reg_addr_q] <= ind_reg_wdata_q;
	end
endmodule

// >>> jrt_ram_test_chk.sv
`timescale 1ns/10ps
module jrt_ram_test_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire jrt_pkg::jrt_req_s req,
	input wire logic memory_test_route_select,
	input wire logic rvalid_q,
	input wire logic ind_reg_wr_q,
	input wire logic [10:0] ind_reg_addr_q,
	input wire logic [15:0] ind_reg_wdata_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_dw;
		req.wr && req.addr == jrt_pkg::OFS_IND_DATA;
	endsequence
	sequence s_cw;
		req.wr && req.addr == jrt_pkg::OFS_IND_CTRL;
	endsequence
	AST_RD_ANS: assert property (req.rd |-> ##2 rvalid_q) else $error("no answer");
	AST_RD_CAUSE: assert property (rvalid_q |-> $past(req.rd, 2)) else $error("stray valid");
	AST_WR_SILENT: assert property (req.wr |-> ##2 !rvalid_q) else $error("write answered");
	AST_IND_WR: assert property (s_dw ##0 !memory_test_route_select |=>
		ind_reg_wr_q && ind_reg_wdata_q == $past(req.wdata)) else $error("no ind write");
	AST_MEM_WR: assert property (s_dw ##0 memory_test_route_select |=> !ind_reg_wr_q)
		else $error("mem write leaked");
	AST_WR_CAUSE: assert property (ind_reg_wr_q |-> $past(req.wr && req.addr == 8'h1F))
		else $error("stray ind write");
	AST_ADDR_LOAD: assert property (s_cw |-> ##2 ind_reg_addr_q == $past(req.wdata[10:0], 2))
		else $error("addr not loaded");
	AST_ADDR_HOLD: assert property (!(req.wr && req.addr == 8'h1E) |-> ##2 $stable(ind_reg_addr_q))
		else $error("addr moved");
endmodule
bind jrt_ram_test jrt_ram_test_chk jrt_ram_test_chk_i (.*);

// >>> jrt_ram_test_tb.sv
`timescale 1ns/10ps
module jrt_ram_test_tb;
	localparam logic [7:0] TC = jrt_pkg::OFS_RAM_TEST_CTRL;
	localparam logic [7:0] IC = jrt_pkg::OFS_IND_CTRL;
	localparam logic [7:0] DR = jrt_pkg::OFS_IND_DATA;
	logic mclk, rst, memory_test_route_select, rvalid_q, ind_reg_wr_q;
	jrt_pkg::jrt_req_s req;
	logic [15:0] ind_reg_rdata, rdata_q, ind_reg_wdata_q, d0, d1;
	logic [10:0] ind_reg_addr_q;
	int fails, compares;
	jrt_ram_test jrt_ram_test_i (.*);
	jrt_ind_model jrt_ind_model_i (.*);
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge mclk);
		req <= '0;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge mclk);
		req <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge mclk);
		req <= '0;
		for (int i = 0; i < 4 && rvalid_q !== 1'b1; i++)
			@(negedge mclk);
		chk({15'h0000, rvalid_q}, 16'h0001);
		chk(rdata_q, exp);
	endtask
	// Read control word for memory m at word 799
	function automatic logic [15:0] ctl(input int m);
		logic [2:0] idx = 3'(m);
		return {1'b0, m == 16, m < 8, (m == 16) ? 3'($urandom) : idx, 10'h31F};
	endfunction
	task results;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		mclk = 0;
		forever #2 mclk = ~mclk;
	end
	initial
	begin
		#20000;
		fails++;
		results;
	end
	initial
	begin
		rst = 1;
		req = '0;
		memory_test_route_select = 0;
		void'($urandom(87976));
		repeat (5) @(posedge mclk);
		rst <= 0;
		rd(TC, 16'h0000);
		rd(IC, 16'h0000);
		for (int i = 0; i < 4; i++)
		begin
			d0 = 16'($urandom);
			d1 = 16'($urandom);
			wr(IC, d0);
			repeat (2) @(negedge mclk);
			chk({5'h00, ind_reg_addr_q}, {5'h00, d0[10:0]});
			wr(DR, d1);
			rd(DR, d1);
		end
		@(posedge mclk);
		memory_test_route_select <= 1;
		wr(TC, 16'hC31F);
		wr(DR, d0);
		wr(DR, d1);
		for (int m = 0; m < 17; m++)
		begin
			wr(TC, ctl(m));
			wr(IC, 16'($urandom));
			rd(DR, d0);
			rd(DR, d1);
		end
		results;
	end
endmodule
